// file: rtl/nsl_burst.sv
// burst report sequencer: one report byte per read of the burst register
module nsl_burst
  import nsl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire nsl_frame_t frame_i,
  input  wire logic       adv_i,
  input  wire logic       restart_i,
  output logic [7:0]      byte_o
);
  logic [3:0] idx_q, idx_d;
  nsl_frame_t snap_q, snap_d;

  function automatic logic [7:0] burst_byte(input logic [3:0] i, input nsl_frame_t f);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      4'h0:    b = nsl_motion_byte(f);
      4'h1:    b = f.observation;
      4'h2:    b = f.delta_x[7:0];
      4'h3:    b = f.delta_x[15:8];
      4'h4:    b = f.delta_y[7:0];
      4'h5:    b = f.delta_y[15:8];
      4'h6:    b = f.quality;
      4'h7:    b = f.pixel_sum;
      4'h8:    b = f.pixel_max;
      4'h9:    b = f.pixel_min;
      4'ha:    b = f.shutter[15:8];
      4'hb:    b = f.shutter[7:0];
      4'he:    b = f.surface_quality_alt;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : burst_byte

  // byte 0 is live; the rest come from a snapshot so one report stays coherent
  always_comb begin
    idx_d  = idx_q;
    snap_d = snap_q;
    if (restart_i) begin
      idx_d = 4'h0;
    end else if (adv_i) begin
      if (idx_q == 4'h0) begin
        snap_d = frame_i;
      end
      idx_d = (idx_q == BURST_LAST) ? 4'h0 : 4'(idx_q + 4'h1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      idx_q  <= 4'h0;
      snap_q <= '0;
    end else begin
      idx_q  <= idx_d;
      snap_q <= snap_d;
    end
  end

  assign byte_o = burst_byte(idx_q, (idx_q == 4'h0) ? frame_i : snap_q);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  chk_burst_snapshot: assert property (adv_i && !restart_i && idx_q == 4'h0 |=> idx_q == 4'h1 && snap_q == $past(frame_i))
    else $error("burst snapshot not taken at byte 0 read");
  chk_burst_wrap: assert property (adv_i && !restart_i && idx_q == BURST_LAST |=> idx_q == 4'h0)
    else $error("burst index did not wrap after byte 14");
  cov_burst_full: cover property (adv_i && idx_q == BURST_LAST);
endmodule : nsl_burst

// file: rtl/nsl_pkg.sv
// shared constants and types for the sensor shutdown, mode and lift calibration block
package nsl_pkg;
  localparam int          AXI_AW         = 12;
  localparam int          AXI_DW         = 32;
  localparam int          IDX_LSB        = 2;
  localparam int          IDX_MSB        = 8;
  localparam int          MAP_MSB        = 11;
  localparam logic [2:0]  MAP_HI_ZERO    = 3'h0;
  // register indices: byte address is four times the index
  localparam logic [6:0]  REG_MOTION     = 7'h02;
  localparam logic [6:0]  REG_BURST      = 7'h16;
  localparam logic [6:0]  REG_PWRUP      = 7'h3a;
  localparam logic [6:0]  REG_SHUTDOWN   = 7'h3b;
  localparam logic [6:0]  REG_PERF       = 7'h40;
  localparam logic [6:0]  REG_CAL_CTRL   = 7'h40;
  localparam logic [6:0]  REG_CAL_STATUS = 7'h4c;
  localparam logic [6:0]  REG_LIFT_A     = 7'h4d;
  localparam logic [6:0]  REG_LIFT_CFG   = 7'h4e;
  localparam logic [6:0]  REG_BANK       = 7'h7f;
  localparam logic [7:0]  BANK_MAIN      = 8'h00;
  localparam logic [7:0]  BANK_CAL       = 8'h04;
  localparam logic [7:0]  BANK_LIFT      = 8'h0c;
  localparam logic [7:0]  VAL_SHUTDOWN   = 8'hb6;
  localparam logic [7:0]  VAL_PWRUP      = 8'h5a;
  localparam logic [7:0]  VAL_CAL_START  = 8'hc1;
  localparam logic [7:0]  VAL_CAL_STOP   = 8'h40;
  localparam logic [7:0]  RST_PERF       = 8'h00;
  localparam logic [7:0]  RST_LIFT_CFG   = 8'h08;
  localparam logic [7:0]  RST_BANK       = 8'h00;
  localparam logic [7:0]  RST_LIFT_A     = 8'h00;
  localparam int          LIFT_2MM_BIT   = 0;
  localparam int          MODE_W         = 2;
  localparam logic [3:0]  CAL_IDLE       = 4'h0;
  localparam logic [3:0]  CAL_FAIL       = 4'h1;
  localparam logic [3:0]  CAL_OK         = 4'h5;
  localparam logic [3:0]  BURST_LAST     = 4'he;
  localparam int          MOT_BIT        = 7;
  localparam int          LIFT_BIT       = 3;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic        motion;
    logic        lifted;
    logic [1:0]  op_mode;
    logic [7:0]  observation;
    logic [15:0] delta_x;
    logic [15:0] delta_y;
    logic [7:0]  quality;
    logic [7:0]  pixel_sum;
    logic [7:0]  pixel_max;
    logic [7:0]  pixel_min;
    logic [15:0] shutter;
    logic [7:0]  surface_quality_alt;
  } nsl_frame_t;

  typedef enum logic [0:0] {CS_IDLE, CS_RUN} nsl_cal_state_t;

  function automatic logic [7:0] nsl_motion_byte(input nsl_frame_t f);
    logic [7:0] b;
    b           = 8'h00;
    b[MOT_BIT]  = f.motion;
    b[LIFT_BIT] = f.lifted;
    b[1:0]      = f.op_mode;
    return b;
  endfunction : nsl_motion_byte
endpackage : nsl_pkg

// file: rtl/nsl_top.sv
// sensor control core: shutdown, performance mode, lift config and calibration over axi4-lite
// Notes on behaviour
// - writing 0xb6 to register 0x3b puts the sensor into shutdown.
// - in shutdown every selected command except the power-up write is discarded.
// - clock and data are ignored while select is high, functional while low.
// - after power-up the sensor runs in high performance mode.
// - lift cut-off of 1mm or 2mm for all surfaces, 1mm after power-up.
// - calibration result sits in 0x4c bits 3:0, 5 success, else failure.
// - burst report byte order ends with alternate quality at byte 14.
// - banked registers reached by bank write to 0x7f, access, then 0x00.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
module nsl_top
  import nsl_pkg::*;
#(
  parameter int CAL_MIN_FRAMES = 16,
  parameter int CNT_W          = 16
) (
  input  wire logic              CLK_SYS_I,
  input  wire logic              SRST_I,
  input  wire logic              HARD_RESET_N_I,
  input  wire logic              SENSOR_SELECT_N_I,
  input  wire logic              FRAME_VALID_I,
  input  wire nsl_frame_t        SENSOR_FRAME_I,
  input  wire logic [AXI_AW-1:0] AXI_AWADDR_I,
  input  wire logic              AXI_AWVALID_I,
  output logic                   AXI_AWREADY_O,
  input  wire logic [AXI_DW-1:0] AXI_WDATA_I,
  input  wire logic [3:0]        AXI_WSTRB_I,
  input  wire logic              AXI_WVALID_I,
  output logic                   AXI_WREADY_O,
  output logic [1:0]             AXI_BRESP_O,
  output logic                   AXI_BVALID_O,
  input  wire logic              AXI_BREADY_I,
  input  wire logic [AXI_AW-1:0] AXI_ARADDR_I,
  input  wire logic              AXI_ARVALID_I,
  output logic                   AXI_ARREADY_O,
  output logic [AXI_DW-1:0]      AXI_RDATA_O,
  output logic [1:0]             AXI_RRESP_O,
  output logic                   AXI_RVALID_O,
  input  wire logic              AXI_RREADY_I,
  output logic [MODE_W-1:0]      PERF_MODE_O,
  output logic                   SHUTDOWN_O,
  output logic                   LIFT_2MM_O,
  output logic                   CAL_ACTIVE_O
);
  localparam logic [CNT_W-1:0] CNT_MIN = CNT_W'(CAL_MIN_FRAMES);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  // write channel state
  logic             aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic             awready_q, awready_d, wready_q, wready_d;
  logic             bvalid_q, bvalid_d;
  logic [1:0]       bresp_q, bresp_d;
  logic [6:0]       aw_idx_q, aw_idx_d;
  logic             aw_ok_q, aw_ok_d;
  logic [7:0]       w_byte_q, w_byte_d;
  logic             w_en_q, w_en_d;
  // read channel state
  logic             arready_q, arready_d, rvalid_q, rvalid_d;
  logic [AXI_DW-1:0] rdata_q, rdata_d;
  logic [1:0]       rresp_q, rresp_d;
  // device registers
  logic             shutdown_q, shutdown_d;
  logic [7:0]       bank_q, bank_d, perf_q, perf_d, lift_cfg_q, lift_cfg_d;
  // calibration
  nsl_cal_state_t   cal_st_q, cal_st_d;
  logic             cal_act_q, cal_act_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0]       peak_q, peak_d, lift_a_q, lift_a_d;
  logic [3:0]       status_q, status_d;

  logic             do_wr, wr_eff, pwrup_cmd, powerup, cal_start, cal_stop;
  logic             ar_take, rd_eff, burst_adv, burst_restart;
  logic [6:0]       ar_idx;
  logic [7:0]       burst_byte, rd_byte;

  function automatic logic addr_mapped(input logic [AXI_AW-1:0] a);
    return a[MAP_MSB:IDX_MSB+1] == MAP_HI_ZERO;
  endfunction : addr_mapped

  function automatic logic hit(input logic [6:0] idx, input logic [7:0] bank,
                               input logic [6:0] ridx, input logic [7:0] rbank);
    return (idx == ridx) && (bank == rbank);
  endfunction : hit

  // write path: address and data taken in either order, one response after both
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    aw_idx_d  = aw_idx_q;
    aw_ok_d   = aw_ok_q;
    w_byte_d  = w_byte_q;
    w_en_d    = w_en_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    do_wr     = aw_have_q && w_have_q && !bvalid_q;
    if (AXI_AWVALID_I && awready_q) begin
      aw_have_d = 1'b1;
      aw_idx_d  = AXI_AWADDR_I[IDX_MSB:IDX_LSB];
      aw_ok_d   = addr_mapped(AXI_AWADDR_I);
    end
    if (AXI_WVALID_I && wready_q) begin
      w_have_d = 1'b1;
      w_byte_d = AXI_WDATA_I[7:0];
      w_en_d   = AXI_WSTRB_I[0];
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = aw_ok_q ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && AXI_BREADY_I) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
  end

  // select high leaves the port deaf: the access is answered but has no effect
  assign wr_eff    = do_wr && aw_ok_q && w_en_q && !SENSOR_SELECT_N_I;
  assign pwrup_cmd = wr_eff && aw_idx_q == REG_PWRUP && w_byte_q == VAL_PWRUP;
  assign powerup   = pwrup_cmd || !HARD_RESET_N_I;
  assign cal_start = wr_eff && !shutdown_q && hit(aw_idx_q, bank_q, REG_CAL_CTRL, BANK_CAL)
                     && w_byte_q == VAL_CAL_START;
  assign cal_stop  = wr_eff && !shutdown_q && hit(aw_idx_q, bank_q, REG_CAL_CTRL, BANK_CAL)
                     && w_byte_q == VAL_CAL_STOP;
  assign burst_restart = wr_eff && !shutdown_q && hit(aw_idx_q, bank_q, REG_BURST, BANK_MAIN);

  // device registers
  always_comb begin
    shutdown_d = shutdown_q;
    bank_d     = bank_q;
    perf_d     = perf_q;
    lift_cfg_d = lift_cfg_q;
    if (powerup) begin
      shutdown_d = 1'b0;
      bank_d     = RST_BANK;
      perf_d     = RST_PERF;
      lift_cfg_d = RST_LIFT_CFG;
    end else if (wr_eff && !shutdown_q) begin
      if (aw_idx_q == REG_BANK) begin
        bank_d = w_byte_q;
      end
      if (aw_idx_q == REG_SHUTDOWN && w_byte_q == VAL_SHUTDOWN) begin
        shutdown_d = 1'b1;
      end
      if (hit(aw_idx_q, bank_q, REG_PERF, BANK_MAIN)) begin
        perf_d = w_byte_q;
      end
      if (hit(aw_idx_q, bank_q, REG_LIFT_CFG, BANK_LIFT)) begin
        lift_cfg_d = w_byte_q;
      end
    end
  end

  // calibration: counts frames seen while running, keeps peak quality as parameter a
  always_comb begin
    cal_st_d = cal_st_q;
    cnt_d    = cnt_q;
    peak_d   = peak_q;
    status_d = status_q;
    lift_a_d = lift_a_q;
    if (powerup) begin
      cal_st_d = CS_IDLE;
      cnt_d    = '0;
      peak_d   = 8'h00;
      status_d = CAL_IDLE;
      lift_a_d = RST_LIFT_A;
    end else begin
      unique case (cal_st_q)
        CS_IDLE: begin
          if (cal_start) begin
            cal_st_d = CS_RUN;
            cnt_d    = '0;
            peak_d   = 8'h00;
            status_d = CAL_IDLE;
          end
        end
        CS_RUN: begin
          if (FRAME_VALID_I) begin
            cnt_d  = (cnt_q == CNT_MAX) ? cnt_q : CNT_W'(cnt_q + 1'b1);
            peak_d = (SENSOR_FRAME_I.quality > peak_q) ? SENSOR_FRAME_I.quality : peak_q;
          end
          if (cal_stop) begin
            cal_st_d = CS_IDLE;
            status_d = (cnt_d >= CNT_MIN) ? CAL_OK : CAL_FAIL;
            lift_a_d = peak_d;
          end
        end
      endcase
    end
    cal_act_d = (cal_st_d == CS_RUN);
  end

  // read path: one register per request, answered the cycle after it is taken
  assign ar_take   = AXI_ARVALID_I && arready_q;
  assign ar_idx    = AXI_ARADDR_I[IDX_MSB:IDX_LSB];
  assign rd_eff    = ar_take && addr_mapped(AXI_ARADDR_I) && !SENSOR_SELECT_N_I && !shutdown_q;
  assign burst_adv = rd_eff && hit(ar_idx, bank_q, REG_BURST, BANK_MAIN);

  always_comb begin
    rd_byte = 8'h00;
    if (ar_idx == REG_BANK) begin
      rd_byte = bank_q;
    end else if (hit(ar_idx, bank_q, REG_MOTION, BANK_MAIN)) begin
      rd_byte = nsl_motion_byte(SENSOR_FRAME_I);
    end else if (hit(ar_idx, bank_q, REG_BURST, BANK_MAIN)) begin
      rd_byte = burst_byte;
    end else if (hit(ar_idx, bank_q, REG_PERF, BANK_MAIN)) begin
      rd_byte = perf_q;
    end else if (hit(ar_idx, bank_q, REG_CAL_STATUS, BANK_CAL)) begin
      rd_byte = {4'h0, status_q};
    end else if (hit(ar_idx, bank_q, REG_LIFT_A, BANK_CAL)) begin
      rd_byte = lift_a_q;
    end else if (hit(ar_idx, bank_q, REG_LIFT_CFG, BANK_LIFT)) begin
      rd_byte = lift_cfg_q;
    end
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (ar_take) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rdata_d   = rd_eff ? {24'h000000, rd_byte} : '0;
      rresp_d   = addr_mapped(AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && AXI_RREADY_I) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end else if (!rvalid_q) begin
      arready_d = 1'b1;
    end
  end

  nsl_burst u_burst (
    .clk_i     (CLK_SYS_I),
    .srst_i    (SRST_I || powerup),
    .frame_i   (SENSOR_FRAME_I),
    .adv_i     (burst_adv),
    .restart_i (burst_restart),
    .byte_o    (burst_byte)
  );

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      aw_have_q <= 1'b0; w_have_q <= 1'b0; awready_q <= 1'b0; wready_q <= 1'b0;
      bvalid_q  <= 1'b0; bresp_q <= RESP_OKAY; aw_idx_q <= 7'h00; aw_ok_q <= 1'b0;
      w_byte_q  <= 8'h00; w_en_q <= 1'b0;
      arready_q <= 1'b0; rvalid_q <= 1'b0; rdata_q <= '0; rresp_q <= RESP_OKAY;
      shutdown_q <= 1'b0; bank_q <= RST_BANK; perf_q <= RST_PERF; lift_cfg_q <= RST_LIFT_CFG;
      cal_st_q  <= CS_IDLE; cal_act_q <= 1'b0; cnt_q <= '0; peak_q <= 8'h00;
      status_q  <= CAL_IDLE; lift_a_q <= RST_LIFT_A;
    end else begin
      aw_have_q <= aw_have_d; w_have_q <= w_have_d; awready_q <= awready_d; wready_q <= wready_d;
      bvalid_q  <= bvalid_d; bresp_q <= bresp_d; aw_idx_q <= aw_idx_d; aw_ok_q <= aw_ok_d;
      w_byte_q  <= w_byte_d; w_en_q <= w_en_d;
      arready_q <= arready_d; rvalid_q <= rvalid_d; rdata_q <= rdata_d; rresp_q <= rresp_d;
      shutdown_q <= shutdown_d; bank_q <= bank_d; perf_q <= perf_d; lift_cfg_q <= lift_cfg_d;
      cal_st_q  <= cal_st_d; cal_act_q <= cal_act_d; cnt_q <= cnt_d; peak_q <= peak_d;
      status_q  <= status_d; lift_a_q <= lift_a_d;
    end
  end

  assign AXI_AWREADY_O = awready_q;
  assign AXI_WREADY_O  = wready_q;
  assign AXI_BVALID_O  = bvalid_q;
  assign AXI_BRESP_O   = bresp_q;
  assign AXI_ARREADY_O = arready_q;
  assign AXI_RVALID_O  = rvalid_q;
  assign AXI_RDATA_O   = rdata_q;
  assign AXI_RRESP_O   = rresp_q;
  assign PERF_MODE_O   = perf_q[MODE_W-1:0];
  assign SHUTDOWN_O    = shutdown_q;
  assign LIFT_2MM_O    = lift_cfg_q[LIFT_2MM_BIT];
  assign CAL_ACTIVE_O  = cal_act_q;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);

  chk_shutdown_entry: assert property (
    wr_eff && !shutdown_q && HARD_RESET_N_I && aw_idx_q == REG_SHUTDOWN && w_byte_q == VAL_SHUTDOWN
    |=> SHUTDOWN_O)
    else $error("shutdown command did not enter shutdown");
  chk_shutdown_discard: assert property (
    shutdown_q && do_wr && !powerup |=> SHUTDOWN_O && $stable(perf_q) && $stable(bank_q) && $stable(lift_cfg_q))
    else $error("command acted during shutdown");
  chk_shutdown_read: assert property (shutdown_q && ar_take |=> AXI_RDATA_O == '0)
    else $error("read returned data during shutdown");
  chk_select_ignore: assert property (
    do_wr && SENSOR_SELECT_N_I && HARD_RESET_N_I |=> $stable(perf_q) && $stable(SHUTDOWN_O) && $stable(bank_q))
    else $error("write acted while select high");
  chk_powerup_defaults: assert property (
    pwrup_cmd |=> PERF_MODE_O == RST_PERF[MODE_W-1:0] && !SHUTDOWN_O && !LIFT_2MM_O && bank_q == RST_BANK)
    else $error("power-up did not restore high performance, 1mm");
  chk_mode_write: assert property (
    wr_eff && !shutdown_q && HARD_RESET_N_I && hit(aw_idx_q, bank_q, REG_PERF, BANK_MAIN)
    |=> PERF_MODE_O == $past(w_byte_q[MODE_W-1:0]))
    else $error("mode bits not taken from write");
  chk_cal_result: assert property (
    cal_stop && HARD_RESET_N_I && cal_st_q == CS_RUN
    |=> (status_q == CAL_OK) == ($past(cnt_d) >= CNT_MIN) && !CAL_ACTIVE_O ##1 !CAL_ACTIVE_O)
    else $error("calibration status wrong after stop");
  chk_write_answer: assert property (AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O
    |=> ##1 AXI_BVALID_O)
    else $error("write response not two cycles after address and data");
  chk_read_answer: assert property (ar_take |=> AXI_RVALID_O && !AXI_ARREADY_O)
    else $error("read answer not one cycle after request");

  cov_shutdown_wake: cover property (SHUTDOWN_O ##[1:50] pwrup_cmd);
  cov_cal_success: cover property (cal_stop && cnt_q >= CNT_MIN);
  cov_corded_mode: cover property (PERF_MODE_O == 2'h3);
  cov_lift_2mm: cover property (LIFT_2MM_O);
endmodule : nsl_top

// file: verification/nsl_host_model.sv
// axi4-lite host model standing in for the microcontroller
module nsl_host_model
  import nsl_pkg::*;
(
  input  wire logic              clk_i,
  output logic [AXI_AW-1:0]      awaddr_o,
  output logic                   awvalid_o,
  input  wire logic              awready_i,
  output logic [AXI_DW-1:0]      wdata_o,
  output logic [3:0]             wstrb_o,
  output logic                   wvalid_o,
  input  wire logic              wready_i,
  input  wire logic [1:0]        bresp_i,
  input  wire logic              bvalid_i,
  output logic                   bready_o,
  output logic [AXI_AW-1:0]      araddr_o,
  output logic                   arvalid_o,
  input  wire logic              arready_i,
  input  wire logic [AXI_DW-1:0] rdata_i,
  input  wire logic [1:0]        rresp_i,
  input  wire logic              rvalid_i,
  output logic                   rready_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    awaddr_o  = '0;
    awvalid_o = 1'b0;
    wdata_o   = '0;
    wstrb_o   = 4'h1;
    wvalid_o  = 1'b0;
    bready_o  = 1'b0;
    araddr_o  = '0;
    arvalid_o = 1'b0;
    rready_o  = 1'b0;
  end

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [AXI_AW-1:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic na;
    logic nw;
    @(posedge clk_i);
    awaddr_o  <= a;
    wdata_o   <= {24'h0, d};
    awvalid_o <= 1'b1;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    forever begin
      @(negedge clk_i);
      if (!awvalid_o && !wvalid_o) break;
      na = awvalid_o & awready_i;
      nw = wvalid_o & wready_i;
      @(posedge clk_i);
      if (na) awvalid_o <= 1'b0;
      if (nw) wvalid_o <= 1'b0;
    end
    while (!bvalid_i) @(negedge clk_i);
    resp = bresp_i;
    @(posedge clk_i);
    bready_o <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    @(negedge clk_i);
    while (!arready_i) @(negedge clk_i);
    @(posedge clk_i);
    arvalid_o <= 1'b0;
    @(negedge clk_i);
    while (!rvalid_i) @(negedge clk_i);
    d    = rdata_i;
    resp = rresp_i;
    @(posedge clk_i);
    rready_o <= 1'b0;
  endtask : rd
endmodule : nsl_host_model

// file: verification/testbench.sv
// self-checking bench for the sensor control core
module testbench;
  import nsl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         CAL_FRAMES = 2;
  localparam logic [7:0] MV [4]     = '{8'h00, 8'h01, 8'h02, 8'h83};
  logic              clk_sys = 1'b0;
  logic              srst, hard_n, sel_n, fv, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic              sd_o, lift_o, cal_o;
  logic [1:0]        mode_o, bresp, rresp, rsp;
  logic [AXI_AW-1:0] awa, ara;
  logic [31:0]       wd, rdat, rd_d;
  logic [3:0]        ws;
  logic [119:0]      bexp;
  logic [7:0]        sav;
  int unsigned       acc_q = 0, acc_p = 0, acc_a = 0, thr = 0;
  nsl_frame_t        frm;
  int                n_errors = 0;
  int                total_checks = 0;

  always #5 clk_sys = ~clk_sys;

  nsl_top #(.CAL_MIN_FRAMES(CAL_FRAMES)) u_nsl_top (
    .CLK_SYS_I(clk_sys), .SRST_I(srst), .HARD_RESET_N_I(hard_n), .SENSOR_SELECT_N_I(sel_n),
    .FRAME_VALID_I(fv), .SENSOR_FRAME_I(frm), .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv),
    .AXI_AWREADY_O(awr), .AXI_WDATA_I(wd), .AXI_WSTRB_I(ws), .AXI_WVALID_I(wv), .AXI_WREADY_O(wr_r),
    .AXI_BRESP_O(bresp), .AXI_BVALID_O(bv), .AXI_BREADY_I(br), .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv),
    .AXI_ARREADY_O(arr), .AXI_RDATA_O(rdat), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rv), .AXI_RREADY_I(rr),
    .PERF_MODE_O(mode_o), .SHUTDOWN_O(sd_o), .LIFT_2MM_O(lift_o), .CAL_ACTIVE_O(cal_o));

  nsl_host_model u_host (
    .clk_i(clk_sys), .awaddr_o(awa), .awvalid_o(awv), .awready_i(awr), .wdata_o(wd), .wstrb_o(ws),
    .wvalid_o(wv), .wready_i(wr_r), .bresp_i(bresp), .bvalid_i(bv), .bready_o(br), .araddr_o(ara),
    .arvalid_o(arv), .arready_i(arr), .rdata_i(rdat), .rresp_i(rresp), .rvalid_i(rv), .rready_o(rr));

  task automatic results();
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [AXI_AW-1:0] ra(input logic [6:0] idx);
    return {3'h0, idx, 2'b00};
  endfunction : ra

  task automatic wreg(input logic [6:0] idx, input logic [7:0] d);
    u_host.wr(ra(idx), d, rsp);
    check(32'(rsp), 32'(RESP_OKAY));
  endtask : wreg

  task automatic rchk(input logic [6:0] idx, input logic [7:0] e);
    u_host.rd(ra(idx), rd_d, rsp);
    check(rd_d, {24'h0, e});
  endtask : rchk

  task automatic frame(input logic [7:0] q);
    @(posedge clk_sys);
    frm.quality <= q;
    fv          <= 1'b1;
    @(posedge clk_sys);
    fv <= 1'b0;
  endtask : frame

  initial begin
    srst   = 1'b1;
    hard_n = 1'b1;
    sel_n  = 1'b0;
    fv     = 1'b0;
    frm    = {1'b1, 1'b1, 2'h2, 8'h80, 16'h1234, 16'h5678, 8'h40, 8'h2c, 8'h7e, 8'h03, 16'h0105, 8'h21};
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(32'(mode_o), 32'h0);
    check(32'(lift_o), 32'h0);
    rchk(REG_PERF, RST_PERF);
    wreg(REG_BANK, BANK_LIFT);
    rchk(REG_LIFT_CFG, RST_LIFT_CFG);
    wreg(REG_LIFT_CFG, 8'h09);
    check(32'(lift_o), 32'h1);
    wreg(REG_BANK, BANK_MAIN);
    rchk(REG_LIFT_CFG, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wreg(REG_PERF, MV[m]);
      check(32'(mode_o), 32'(MV[m][1:0]));
      rchk(REG_PERF, MV[m]);
    end
    u_host.rd(ra(REG_PERF), rd_d, rsp);
    wreg(REG_PERF, {rd_d[7:2], 2'h1});
    rchk(REG_PERF, 8'h81);
    check(32'(mode_o), 32'h1);
    wreg(REG_PERF, MV[3]);
    // burst: byte 0 is motion status, byte 14 the alternate quality
    bexp = {frm.surface_quality_alt, 16'h0, frm.shutter[7:0], frm.shutter[15:8], frm.pixel_min, frm.pixel_max,
            frm.pixel_sum, frm.quality, frm.delta_y[15:8], frm.delta_y[7:0], frm.delta_x[15:8],
            frm.delta_x[7:0], frm.observation, frm.motion, 3'h0, frm.lifted, 1'b0, frm.op_mode};
    wreg(REG_BURST, 8'h00);
    for (int i = 0; i < 16; i++) begin
      rchk(REG_BURST, bexp[(i % 15) * 8 +: 8]);
      if (i == 6) acc_q += rd_d;
      if (i == 7) acc_p += rd_d;
      if (i == 14) acc_a += rd_d;
    end
    // one report stands in for the long surface average
    thr = (acc_p < 48) ? 23 : 30;
    check(thr, 32'h17);
    check(32'(acc_a * 100 / acc_q < thr && acc_p < 68), 32'h0);
    // first pass has enough frames, second one too few
    for (int k = 0; k < 2; k++) begin
      u_host.rd(ra(REG_PERF), rd_d, rsp);
      sav = rd_d[7:0];
      wreg(REG_PERF, 8'h80);
      wreg(REG_BANK, BANK_CAL);
      wreg(REG_CAL_CTRL, VAL_CAL_START);
      check(32'(cal_o), 32'h1);
      rchk(REG_CAL_STATUS, {4'h0, CAL_IDLE});
      for (int j = 0; j < CAL_FRAMES - k; j++) frame(8'h30 + 8'(j * 32));
      wreg(REG_CAL_CTRL, VAL_CAL_STOP);
      check(32'(cal_o), 32'h0);
      rchk(REG_CAL_STATUS, {4'h0, ((k == 0) ? CAL_OK : CAL_FAIL)});
      if (k == 0) rchk(REG_LIFT_A, 8'h50);
      wreg(REG_BANK, BANK_LIFT);
      wreg(REG_LIFT_CFG, RST_LIFT_CFG);
      check(32'(lift_o), 32'h0);
      wreg(REG_BANK, BANK_MAIN);
      wreg(REG_PERF, sav);
      rchk(REG_PERF, 8'h83);
    end
    sel_n <= 1'b1;
    wreg(REG_SHUTDOWN, VAL_SHUTDOWN);
    check(32'(sd_o), 32'h0);
    wreg(REG_PERF, 8'h01);
    rchk(REG_PERF, 8'h00);
    sel_n <= 1'b0;
    rchk(REG_PERF, 8'h83);
    wreg(REG_SHUTDOWN, VAL_SHUTDOWN);
    check(32'(sd_o), 32'h1);
    sel_n <= 1'b1;
    wreg(REG_PWRUP, VAL_PWRUP);
    check(32'(sd_o), 32'h1);
    sel_n <= 1'b0;
    wreg(REG_PERF, 8'h01);
    rchk(REG_PERF, 8'h00);
    check(32'(mode_o), 32'h3);
    wreg(REG_PWRUP, VAL_PWRUP);
    check(32'(sd_o), 32'h0);
    check(32'(mode_o), 32'h0);
    u_host.wr(12'h800, 8'h01, rsp);
    check(32'(rsp), 32'(RESP_SLVERR));
    u_host.rd(12'h800, rd_d, rsp);
    check(32'(rsp), 32'(RESP_SLVERR));
    wreg(REG_PERF, 8'h02);
    check(32'(mode_o), 32'h2);
    hard_n <= 1'b0;
    @(posedge clk_sys);
    hard_n <= 1'b1;
    @(posedge clk_sys);
    check(32'(mode_o), 32'h0);
    results();
  end

  // hang guard, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    results();
  end
endmodule : testbench
